/* File: core/clock_control.sv */
// Functional notes
// R1 - five modes: crystal, crystal x4, external, external x4, internal 31 kHz
// R2 - config field picks primary mode; internal by software or default
// R3 - external modes skip oscillator start-up wait at reset and wake
// R4 - plain external mode drives source divided by four on out pin
// R5 - crystal mode with external clock gives no divided output
// R6 - multiplied modes run four times source; if that would exceed 40 MHz, the source runs unmultiplied
// R7 - tuning register bit 6 enables multiplier, resets to zero
// R8 - multiplier enable exists only in multiplied modes, else reads zero
// R9 - tuning register bit 7 and bits 5 to 0 read zero
// R10 - internal oscillator runs from power-up through configuration load
// R11 - internal oscillator runs when selected or monitor, watchdog, two-speed on
// R12 - config bit can make internal oscillator the start-up clock
// R13 - select 00 picks internal when default bit 0, primary when 1
// R14 - two-bit clock select clears on reset; 11 int, 10 pri, 01 sec
// R15 - primary path uses multiplier only in multiplied mode with enable set
`timescale 1ns/100ps
`include "osc_defines.svh"

module clock_control import osc_pkg::*; #(
	parameter int unsigned INT_OSC_CYCLES = `INT_OSC_CYCLES,
	parameter int unsigned CONFIG_LOAD_TICKS = `CONFIG_LOAD_TICKS,
	parameter int unsigned OSC_STARTUP_EDGES = `OSC_STARTUP_EDGES
) (
	// clock and reset
	input logic ref_clk,
	input logic rst_n,
	// oscillator pins
	input logic oscillatorInPin,
	input logic oscillatorOutPinIn,
	output logic oscillatorOutPin,
	output logic oscillatorOutPinOeN,
	// secondary oscillator
	input logic secondaryOscTick,
	// non-volatile configuration
	input logic [2:0] oscillatorConfig,
	// power management
	input logic sleepRequest,
	input logic wakeEvent,
	// register port
	input logic [7:0] regAddr,
	input logic [7:0] regWrData,
	input logic regWrite,
	input logic regRead,
	output logic [7:0] regRdData,
	// clock outputs
	output logic sysClkTick,
	output logic [1:0] activeSource,
	output logic internalOscEnable,
	output logic primaryReady,
	output logic multiplierActive
);

	pll_link_if pllLink();

	ctl_state_e state;
	ctl_state_e next_state;
	logic [2:0] loadedConfig;
	osc_mode_e mode;
	logic defaultSourceConfig;
	logic multiplierEnable;
	logic [1:0] systemClockSelect;
	logic failSafeEn;
	logic watchdogEn;
	logic twoSpeedEn;
	clk_src_e selectedSource;
	clk_src_e next_source;
	logic oscInPrev;
	logic srcTick;
	logic [15:0] intOscCnt;
	logic intTick;
	logic [15:0] cfgCnt;
	logic cfgDone;
	logic [15:0] startupCnt;
	logic startupDone;
	logic [1:0] divCnt;
	logic usePll;
	logic primaryTick;
	logic next_sysTick;
	logic wrPll;
	logic wrSelect;
	logic wrFeature;
	logic [7:0] next_rdData;

	assign mode = osc_mode_e'(loadedConfig[1:0]);
	assign defaultSourceConfig = loadedConfig[`DEFAULT_SOURCE_BIT];

	// source edge detect
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			oscInPrev <= 1'b0;
		end else begin
			oscInPrev <= oscillatorInPin;
		end
	end

	assign srcTick = oscillatorInPin && !oscInPrev && (state != ST_SLEEP);

	// internal oscillator enable
	always_comb begin
		internalOscEnable = (state == ST_CONFIG_LOAD) || // [R10]
			(selectedSource == SRC_INTERNAL) ||
			failSafeEn || watchdogEn || twoSpeedEn; // [R11]
	end

	// internal 31 kHz oscillator
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			intOscCnt <= 16'h0000;
		end else if (!internalOscEnable) begin
			intOscCnt <= 16'h0000;
		end else if (intOscCnt == 16'(INT_OSC_CYCLES - 1)) begin
			intOscCnt <= 16'h0000;
		end else begin
			intOscCnt <= intOscCnt + 16'h0001;
		end
	end

	assign intTick = internalOscEnable &&
		(intOscCnt == 16'(INT_OSC_CYCLES - 1)); // [R1]

	// configuration load counter, clocked by internal ticks
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgCnt <= 16'h0000;
		end else if (state == ST_CONFIG_LOAD && intTick) begin
			cfgCnt <= cfgCnt + 16'h0001;
		end
	end

	assign cfgDone = (state == ST_CONFIG_LOAD) && intTick &&
		(cfgCnt == 16'(CONFIG_LOAD_TICKS - 1)); // [R10]

	// configuration capture at end of load
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			loadedConfig <= `OSC_CONFIG_RST;
		end else if (cfgDone) begin
			loadedConfig <= oscillatorConfig; // [R2] [R12]
		end
	end

	// oscillator start-up counter, crystal modes only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			startupCnt <= 16'h0000;
		end else if (state != ST_STARTUP) begin
			startupCnt <= 16'h0000;
		end else if (srcTick) begin
			startupCnt <= startupCnt + 16'h0001;
		end
	end

	assign startupDone = srcTick &&
		(startupCnt == 16'(OSC_STARTUP_EDGES - 1));

	// control state machine
	always_comb begin
		next_state = state;
		case (state)
			ST_CONFIG_LOAD: begin
				if (cfgDone) begin
					if (isExternal(osc_mode_e'(oscillatorConfig[1:0]))) begin
						next_state = ST_RUN; // [R3]
					end else begin
						next_state = ST_STARTUP;
					end
				end
			end
			ST_STARTUP: begin
				if (sleepRequest) begin
					next_state = ST_SLEEP;
				end else if (startupDone) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sleepRequest) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wakeEvent) begin
					if (isExternal(mode)) begin
						next_state = ST_RUN; // [R3]
					end else begin
						next_state = ST_STARTUP;
					end
				end
			end
			default: begin
				next_state = ST_CONFIG_LOAD;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_CONFIG_LOAD;
		end else begin
			state <= next_state;
		end
	end

	assign primaryReady = (state == ST_RUN);

	// register write decode
	always_comb begin
		wrPll = 1'b0;
		wrSelect = 1'b0;
		wrFeature = 1'b0;
		if (regWrite && regAddr == `PLL_TUNING_CONTROL_OFS) begin
			wrPll = 1'b1;
		end else if (regWrite && regAddr == `CLOCK_SELECT_CONTROL_OFS) begin
			wrSelect = 1'b1;
		end else if (regWrite && regAddr == `FEATURE_ENABLE_OFS) begin
			wrFeature = 1'b1;
		end
	end

	// multiplier enable bit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			multiplierEnable <= 1'b0; // [R7]
		end else if (!isMultiplied(mode) || state == ST_CONFIG_LOAD) begin
			multiplierEnable <= 1'b0; // [R8]
		end else if (wrPll) begin
			multiplierEnable <= regWrData[`MULTIPLIER_ENABLE_BIT]; // [R7]
		end
	end

	// system clock select
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			systemClockSelect <= `CLK_SEL_RST; // [R14]
		end else if (wrSelect) begin
			systemClockSelect <= regWrData[`CLK_SEL_MSB:`CLK_SEL_LSB];
		end
	end

	// feature enables
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{twoSpeedEn, watchdogEn, failSafeEn} <= `FEATURE_ENABLE_RST;
		end else if (wrFeature) begin
			failSafeEn <= regWrData[`FAILSAFE_EN_BIT];
			watchdogEn <= regWrData[`WATCHDOG_EN_BIT];
			twoSpeedEn <= regWrData[`TWO_SPEED_EN_BIT];
		end
	end

	// source selection
	always_comb begin
		if (state == ST_CONFIG_LOAD) begin
			next_source = SRC_INTERNAL; // [R10]
		end else begin
			next_source = decodeSource(systemClockSelect,
				defaultSourceConfig); // [R13] [R14]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			selectedSource <= SRC_INTERNAL;
		end else begin
			selectedSource <= next_source;
		end
	end

	assign activeSource = 2'(selectedSource);

	// frequency multiplier
	assign pllLink.enable = isMultiplied(mode) && multiplierEnable;
	assign pllLink.srcTick = srcTick;

	pll_multiplier u_pll (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.link(pllLink)
	);

	assign usePll = pllLink.enable && pllLink.locked &&
		!pllLink.overspeed; // [R6] [R15]
	assign primaryTick = usePll ? pllLink.multTick : srcTick; // [R15]

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			multiplierActive <= 1'b0;
		end else begin
			multiplierActive <= usePll;
		end
	end

	// system clock tick
	always_comb begin
		next_sysTick = 1'b0;
		case (state)
			ST_CONFIG_LOAD: begin
				next_sysTick = intTick; // [R10]
			end
			ST_SLEEP: begin
				next_sysTick = 1'b0;
			end
			default: begin
				case (selectedSource)
					SRC_PRIMARY: begin
						if (primaryReady) begin
							next_sysTick = primaryTick;
						end else begin
							next_sysTick = twoSpeedEn && intTick;
						end
					end
					SRC_SECONDARY: begin
						next_sysTick = secondaryOscTick;
					end
					default: begin
						next_sysTick = intTick; // [R2]
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sysClkTick <= 1'b0;
		end else begin
			sysClkTick <= next_sysTick;
		end
	end

	// divide-by-four output, plain external mode only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt <= 2'h0;
		end else if (mode != EXTERNAL_CLOCK_MODE || state == ST_SLEEP) begin
			divCnt <= 2'h0; // [R5]
		end else if (srcTick) begin
			divCnt <= divCnt + 2'h1; // [R4]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			oscillatorOutPin <= 1'b0;
			oscillatorOutPinOeN <= 1'b1;
		end else begin
			oscillatorOutPin <= divCnt[1]; // [R4]
			oscillatorOutPinOeN <= !(mode == EXTERNAL_CLOCK_MODE &&
				state != ST_CONFIG_LOAD && state != ST_SLEEP); // [R5]
		end
	end

	// register read decode
	always_comb begin
		next_rdData = 8'h00;
		if (regAddr == `PLL_TUNING_CONTROL_OFS) begin
			next_rdData[`MULTIPLIER_ENABLE_BIT] = multiplierEnable; // [R8] [R9]
		end else if (regAddr == `CLOCK_SELECT_CONTROL_OFS) begin
			next_rdData[`CLK_SEL_MSB:`CLK_SEL_LSB] = systemClockSelect;
			next_rdData[`PRIMARY_READY_BIT] = primaryReady;
			next_rdData[`OVERSPEED_BIT] = pllLink.overspeed;
		end else if (regAddr == `FEATURE_ENABLE_OFS) begin
			next_rdData[`FAILSAFE_EN_BIT] = failSafeEn;
			next_rdData[`WATCHDOG_EN_BIT] = watchdogEn;
			next_rdData[`TWO_SPEED_EN_BIT] = twoSpeedEn;
		end else if (regAddr == `CLOCK_STATUS_OFS) begin
			next_rdData = {oscillatorOutPinIn, activeSource,
				internalOscEnable, loadedConfig, 1'b0};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			regRdData <= next_rdData;
		end else begin
			regRdData <= 8'h00;
		end
	end

endmodule

/* File: core/osc_defines.svh */
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

// register offsets
`define PLL_TUNING_CONTROL_OFS 8'h00
`define CLOCK_SELECT_CONTROL_OFS 8'h01
`define FEATURE_ENABLE_OFS 8'h02
`define CLOCK_STATUS_OFS 8'h03

// field positions
`define MULTIPLIER_ENABLE_BIT 6
`define CLK_SEL_LSB 0
`define CLK_SEL_MSB 1
`define PRIMARY_READY_BIT 3
`define OVERSPEED_BIT 4
`define FAILSAFE_EN_BIT 0
`define WATCHDOG_EN_BIT 1
`define TWO_SPEED_EN_BIT 2
`define DEFAULT_SOURCE_BIT 2

// reset values
`define PLL_TUNING_CONTROL_RST 8'h00
`define CLK_SEL_RST 2'h0
`define FEATURE_ENABLE_RST 3'h0
`define OSC_CONFIG_RST 3'h4

// clock select codes
`define CLK_SEL_DEFAULT 2'h0
`define CLK_SEL_SECONDARY 2'h1
`define CLK_SEL_PRIMARY 2'h2
`define CLK_SEL_INTERNAL 2'h3

// timing
`define REF_CLK_HZ 200_000_000
`define INT_OSC_HZ 31_000
`define INT_OSC_CYCLES (`REF_CLK_HZ / `INT_OSC_HZ)
`define MAX_SYS_CLK_HZ 40_000_000
`define MIN_TICK_CYCLES ((`REF_CLK_HZ + `MAX_SYS_CLK_HZ - 1) / `MAX_SYS_CLK_HZ)
`define PLL_FACTOR 4
`define MIN_SRC_PERIOD (`PLL_FACTOR * `MIN_TICK_CYCLES)
`define CONFIG_LOAD_TICKS 8
`define OSC_STARTUP_EDGES 1024

`endif

/* File: core/osc_pkg.sv */
`include "osc_defines.svh"

package osc_pkg;

	typedef enum logic [1:0] {
		FAST_CRYSTAL_MODE,
		FAST_CRYSTAL_MULTIPLIED_MODE,
		EXTERNAL_CLOCK_MODE,
		EXTERNAL_CLOCK_MULTIPLIED_MODE
	} osc_mode_e;

	typedef enum logic [1:0] {
		SRC_PRIMARY,
		SRC_SECONDARY,
		SRC_INTERNAL
	} clk_src_e;

	typedef enum logic [1:0] {
		ST_CONFIG_LOAD,
		ST_STARTUP,
		ST_RUN,
		ST_SLEEP
	} ctl_state_e;

	function automatic logic isMultiplied(input osc_mode_e mode);
		isMultiplied = (mode == FAST_CRYSTAL_MULTIPLIED_MODE) ||
			(mode == EXTERNAL_CLOCK_MULTIPLIED_MODE);
	endfunction

	function automatic logic isExternal(input osc_mode_e mode);
		isExternal = (mode == EXTERNAL_CLOCK_MODE) ||
			(mode == EXTERNAL_CLOCK_MULTIPLIED_MODE);
	endfunction

	function automatic clk_src_e decodeSource(input logic [1:0] sel,
		input logic defaultSource);
		if (sel == `CLK_SEL_INTERNAL) begin
			decodeSource = SRC_INTERNAL;
		end else if (sel == `CLK_SEL_PRIMARY) begin
			decodeSource = SRC_PRIMARY;
		end else if (sel == `CLK_SEL_SECONDARY) begin
			decodeSource = SRC_SECONDARY;
		end else begin
			decodeSource = defaultSource ? SRC_PRIMARY : SRC_INTERNAL;
		end
	endfunction

endpackage

/* File: core/pll_link_if.sv */
`timescale 1ns/100ps

interface pll_link_if;
	logic enable;
	logic srcTick;
	logic multTick;
	logic locked;
	logic overspeed;

	modport ctrl(output enable, output srcTick,
		input multTick, input locked, input overspeed);
	modport pll(input enable, input srcTick,
		output multTick, output locked, output overspeed);
endinterface

/* File: core/pll_multiplier.sv */
`timescale 1ns/100ps
`include "osc_defines.svh"

module pll_multiplier import osc_pkg::*; (
	// clock and reset
	input logic ref_clk,
	input logic rst_n,
	// link to the clock controller
	pll_link_if.pll link
);

	logic [15:0] periodCnt;
	logic [15:0] lastPeriod;
	logic [15:0] stepCnt;
	logic [1:0] edgesSeen;
	logic [15:0] step;

	assign step = lastPeriod >> 2;

	// source period measurement
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			periodCnt <= 16'h0000;
			lastPeriod <= 16'h0000;
			edgesSeen <= 2'h0;
		end else if (!link.enable) begin
			periodCnt <= 16'h0000;
			edgesSeen <= 2'h0;
		end else if (link.srcTick) begin
			periodCnt <= 16'h0001;
			lastPeriod <= periodCnt;
			if (edgesSeen != 2'h2) begin
				edgesSeen <= edgesSeen + 2'h1;
			end
		end else if (periodCnt != 16'hffff) begin
			periodCnt <= periodCnt + 16'h0001;
		end
	end

	// four output ticks per source period, realigned on each edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stepCnt <= 16'h0000;
			link.multTick <= 1'b0;
		end else if (!link.enable || link.srcTick) begin
			stepCnt <= 16'h0001;
			link.multTick <= link.enable && link.locked;
		end else if (stepCnt >= step && step != 16'h0000) begin
			stepCnt <= 16'h0001;
			link.multTick <= link.locked;
		end else begin
			stepCnt <= stepCnt + 16'h0001;
			link.multTick <= 1'b0;
		end
	end

	assign link.locked = (edgesSeen == 2'h2);
	assign link.overspeed = link.locked &&
		(lastPeriod < 16'(`MIN_SRC_PERIOD));

endmodule

/* File: test/clock_control_chk.sv */
`timescale 1ns/100ps

module clock_control_chk #(
	parameter int unsigned INT_OSC_CYCLES = 8,
	parameter int unsigned CONFIG_LOAD_TICKS = 2,
	parameter int unsigned OSC_STARTUP_EDGES = 4
) (
	// clock and reset
	input logic ref_clk,
	input logic rst_n,
	// pins and strap
	input logic oscillatorInPin,
	input logic oscillatorOutPinOeN,
	input logic [2:0] oscillatorConfig,
	// register port
	input logic [7:0] regAddr,
	input logic regRead,
	input logic [7:0] regRdData,
	// clock outputs
	input logic sysClkTick,
	input logic [1:0] activeSource,
	input logic internalOscEnable,
	input logic primaryReady,
	input logic multiplierActive
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence srcRise;
		!oscillatorInPin ##1 oscillatorInPin;
	endsequence
	sequence tuningRead;
		regRead && regAddr == 8'h00;
	endsequence

	chk_oe_ext: assert property (
		!oscillatorOutPinOeN |-> oscillatorConfig[1:0] == 2'h2)
		else $error("out pin driven outside plain external mode");
	chk_mult_mode: assert property (
		multiplierActive |-> oscillatorConfig[0])
		else $error("multiplier active in unmultiplied mode");
	chk_tuning_bits: assert property (
		tuningRead |=> regRdData[7] == 1'b0 && regRdData[5:0] == 6'h00)
		else $error("unimplemented tuning bits not zero");
	chk_no_pll: assert property (
		tuningRead ##0 !oscillatorConfig[0] |=> regRdData == 8'h00)
		else $error("multiplier enable visible without multiplied mode");
	chk_int_boot: assert property (
		$rose(rst_n) |-> internalOscEnable [*8])
		else $error("internal oscillator off during config load");
	chk_tick_gap: assert property (
		sysClkTick |=> !sysClkTick)
		else $error("system tick faster than limit");
	chk_int_sel: assert property (
		activeSource == 2'h2 |-> internalOscEnable)
		else $error("internal oscillator off while selected");
	chk_ext_tick: assert property (
		srcRise ##0 (activeSource == 2'h0 && primaryReady &&
		!multiplierActive) |=> sysClkTick)
		else $error("source edge gave no system tick");
endmodule

bind clock_control clock_control_chk #(
	.INT_OSC_CYCLES(INT_OSC_CYCLES),
	.CONFIG_LOAD_TICKS(CONFIG_LOAD_TICKS),
	.OSC_STARTUP_EDGES(OSC_STARTUP_EDGES)
) clock_control_chk_i (.ref_clk, .rst_n, .oscillatorInPin,
	.oscillatorOutPinOeN, .oscillatorConfig, .regAddr, .regRead,
	.regRdData, .sysClkTick, .activeSource, .internalOscEnable,
	.primaryReady, .multiplierActive);

/* File: test/ext_clock_src.sv */
`timescale 1ns/100ps

module ext_clock_src (
	// clock
	input logic ref_clk,
	// control
	input logic run,
	input int half,
	// source
	output logic srcPin
);
	int cnt = 0;

	initial srcPin = 1'b0;

	// source stands low while stopped
	always @(posedge ref_clk) begin
		if (!run) begin
			cnt <= 0;
			srcPin <= 1'b0;
		end else if (cnt >= half - 1) begin
			cnt <= 0;
			srcPin <= !srcPin;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

/* File: test/clock_control_tb_top.sv */
`timescale 1ns/100ps

module clock_control_tb_top;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic srcRun = 1'b1;
	int srcHalf = 20;
	logic secondaryOscTick = 1'b0;
	logic [2:0] oscillatorConfig = 3'h6;
	logic sleepRequest = 1'b0;
	logic wakeEvent = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdData;
	logic oscillatorInPin, oscillatorOutPin, oscillatorOutPinOeN, outPinWire;
	logic sysClkTick, internalOscEnable, primaryReady, multiplierActive;
	logic [1:0] activeSource;
	logic [1:0] srcOf [4] = '{2'h2, 2'h1, 2'h0, 2'h2};
	int errTotal = 0;
	int checksDone = 0;

	// out pin pulled low when released
	assign outPinWire = oscillatorOutPinOeN ? 1'b0 : oscillatorOutPin;

	ext_clock_src ext_clock_src_i (.ref_clk(ref_clk),
		.run(srcRun), .half(srcHalf), .srcPin(oscillatorInPin));

	clock_control #(.INT_OSC_CYCLES(8), .CONFIG_LOAD_TICKS(2),
		.OSC_STARTUP_EDGES(4)) clock_control_i (.ref_clk(ref_clk),
		.rst_n(rst_n), .oscillatorInPin(oscillatorInPin),
		.oscillatorOutPinIn(outPinWire), .oscillatorOutPin(oscillatorOutPin),
		.oscillatorOutPinOeN(oscillatorOutPinOeN),
		.secondaryOscTick(secondaryOscTick),
		.oscillatorConfig(oscillatorConfig), .sleepRequest(sleepRequest),
		.wakeEvent(wakeEvent), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.sysClkTick(sysClkTick), .activeSource(activeSource),
		.internalOscEnable(internalOscEnable), .primaryReady(primaryReady),
		.multiplierActive(multiplierActive));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic giveVerdict();
		$display("checks %0d errors %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check8(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checksDone++;
		if (got !== exp) begin
			errTotal++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		check8("regRdData", exp, regRdData);
	endtask

	task automatic boot(input logic [2:0] cfg);
		int n;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		oscillatorConfig <= cfg;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		check8("intOscBoot", 8'h01, {7'h0, internalOscEnable});
		n = 0;
		while (primaryReady !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check8("primaryReady", 8'h01, {7'h0, primaryReady});
	endtask

	task automatic waitMult(input logic v);
		int n;
		n = 0;
		while (multiplierActive !== v && n < 300) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check8("multiplierActive", {7'h0, v}, {7'h0, multiplierActive});
	endtask

	// ticks and out pin toggles over four source periods
	task automatic measure(input int expTicks, input int expToggles);
		int ticks;
		int togs;
		logic last;
		ticks = 0;
		togs = 0;
		@(posedge oscillatorInPin);
		#1;
		last = outPinWire;
		repeat (160) begin
			@(posedge ref_clk);
			#1;
			ticks += sysClkTick;
			togs += (outPinWire !== last);
			last = outPinWire;
		end
		check8("ticks", 8'(expTicks), 8'(ticks));
		check8("toggles", 8'(expToggles), 8'(togs));
	endtask

	task automatic sleepWake(input logic [7:0] expReady);
		@(posedge ref_clk);
		sleepRequest <= 1'b1;
		@(posedge ref_clk);
		sleepRequest <= 1'b0;
		repeat (4) @(posedge ref_clk);
		wakeEvent <= 1'b1;
		@(posedge ref_clk);
		wakeEvent <= 1'b0;
		@(posedge ref_clk);
		#1;
		check8("wakeReady", expReady, {7'h0, primaryReady});
	endtask

	initial begin
		boot(3'h6);
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h08);
		rd(8'h02, 8'h00);
		check8("activeSource", 8'h00, {6'h0, activeSource});
		measure(4, 2);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h00);
		wr(8'h10, 8'hFF);
		rd(8'h10, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(8'h02, 8'(1 << i));
			rd(8'h02, 8'(1 << i));
			check8("intOsc", 8'h01, {7'h0, internalOscEnable});
		end
		wr(8'h02, 8'h00);
		@(posedge ref_clk);
		#1;
		check8("intOsc", 8'h00, {7'h0, internalOscEnable});
		sleepWake(8'h01);
		$display("external mode test done");
		boot(3'h7);
		rd(8'h03, 8'h0E);
		rd(8'h00, 8'h00);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h40);
		waitMult(1'b1);
		measure(16, 0);
		wr(8'h00, 8'h00);
		waitMult(1'b0);
		measure(4, 0);
		srcHalf <= 4;
		wr(8'h00, 8'h40);
		repeat (40) @(posedge ref_clk);
		rd(8'h01, 8'h18);
		check8("overspeedMult", 8'h00, {7'h0, multiplierActive});
		srcHalf <= 20;
		$display("multiplied mode test done");
		boot(3'h4);
		measure(4, 0);
		sleepWake(8'h00);
		$display("crystal mode test done");
		boot(3'h5);
		wr(8'h00, 8'h40);
		rd(8'h00, 8'h40);
		waitMult(1'b1);
		$display("crystal multiplied test done");
		boot(3'h2);
		check8("intOsc", 8'h01, {7'h0, internalOscEnable});
		for (int i = 3; i >= 0; i--) begin
			wr(8'h01, 8'(i));
			rd(8'h01, 8'h08 | 8'(i));
			check8("activeSource", {6'h0, srcOf[i]}, {6'h0, activeSource});
			if (i == 1) begin
				@(posedge ref_clk);
				secondaryOscTick <= 1'b1;
				@(posedge ref_clk);
				secondaryOscTick <= 1'b0;
				#1;
				check8("secTick", 8'h01, {7'h0, sysClkTick});
			end
		end
		$display("clock select test done");
		giveVerdict();
	end

	initial begin
		#(20000 * 5);
		errTotal++;
		giveVerdict();
	end
endmodule
